// >>> hw/mabx_core.sv
`timescale 1ns/1ps
`default_nettype none
module mabx_core
  import mabx_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 8
) (
  input  wire  logic                   mclk,
  input  wire  logic                   nrst,
  input  wire  mabx_pkg::mabx_instr_type instr,
  input  wire  logic [7:0]             mem_rdata,
  input  wire  logic [7:0]             table_rdata,
  input  wire  logic                   wake,
  output logic [10:0]                  pc,
  output logic [7:0]                   mem_addr,
  output logic [7:0]                   mem_wdata,
  output logic                         mem_we,
  output logic [10:0]                  table_addr,
  output logic [7:0]                   accumulator,
  output mabx_pkg::mabx_flags_type     flags,
  output logic                         instr_done,
  output logic                         halted
);
  import mabx_pkg::*;

  initial begin
    if (STACK_DEPTH < 2 || STACK_DEPTH > 16) begin
      $error("mabx_core: STACK_DEPTH must be 2..16");
    end
  end

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_EXTRA = 2'b01,
    ST_HALT  = 2'b10
  } mabx_state_type;

  mabx_state_type state_reg;
  mabx_state_type state_next;
  logic [PHASE_W-1:0] phase_reg;
  logic [7:0]         accumulator_reg;
  mabx_flags_type     flags_reg;
  logic [10:0]        pc_reg;
  logic [10:0]        pc_next;
  logic [10:0]        stack_mem [STACK_DEPTH];
  logic [SP_W-1:0]    sp_reg;
  logic               cycle_end;

  // datapath results
  logic [7:0]     res;
  logic           wr_acc;
  logic           wr_mem;
  mabx_flags_type flags_next;
  logic           extra_cycle;
  logic           skip_taken;
  logic [8:0]     sum9;
  logic [4:0]     low5;
  logic [7:0]     operand_b;
  logic           is_sub;
  logic           use_carry;
  logic [7:0]     bit_mask;

  // a phase counter groups system clocks into instruction cycles
  assign cycle_end = (phase_reg == PHASE_LAST);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= '0;
    end else if (state_reg == ST_HALT) begin
      phase_reg <= '0; // clock grouping rests while halted
    end else begin
      phase_reg <= phase_reg + PHASE_W'(1);
    end
  end

  // one-hot selector from a 3-bit field covers bits 0..7 exactly
  assign bit_mask = 8'h01 << instr.bit_sel;

  // main combinational execute
  always_comb begin
    logic [7:0] a;
    logic [7:0] m;
    a          = accumulator_reg;
    m          = mem_rdata;
    res        = a;
    wr_acc     = 1'b0;
    wr_mem     = 1'b0;
    flags_next = flags_reg;
    extra_cycle = 1'b0;
    skip_taken = 1'b0;
    is_sub     = 1'b0;
    use_carry  = 1'b0;
    operand_b  = m;
    unique case (instr.op)
      OP_ADD_X, OP_SUB_X: operand_b = instr.imm;
      default:            operand_b = m;
    endcase
    unique case (instr.op)
      OP_SUB_X, OP_SUB_M, OP_SUB_TO_M, OP_SBC_M, OP_SBC_TO_M: is_sub = 1'b1;
      default: is_sub = 1'b0;
    endcase
    unique case (instr.op)
      OP_ADC_M, OP_ADC_TO_M, OP_SBC_M, OP_SBC_TO_M: use_carry = 1'b1;
      default: use_carry = 1'b0;
    endcase
    // subtraction is a + ~b + carry-in, so carry=1 means no borrow
    low5 = {1'b0, a[3:0]} + {1'b0, (is_sub ? ~operand_b[3:0] : operand_b[3:0])}
         + {4'h0, (use_carry ? flags_reg.carry : is_sub)};
    sum9 = {1'b0, a} + {1'b0, (is_sub ? ~operand_b : operand_b)}
         + {8'h00, (use_carry ? flags_reg.carry : is_sub)};
    unique case (instr.op)
      OP_ADD_M, OP_ADD_X, OP_ADC_M, OP_SUB_X, OP_SUB_M, OP_SBC_M,
      OP_ADD_TO_M, OP_ADC_TO_M, OP_SUB_TO_M, OP_SBC_TO_M: begin
        res = sum9[7:0];
        flags_next.zero           = (sum9[7:0] == 8'h00);
        flags_next.carry          = sum9[8];
        flags_next.aux_carry_flag = low5[NIBBLE_POS];
        flags_next.overflow_flag  = (a[MSB_POS] == (is_sub ? ~operand_b[MSB_POS]
                                    : operand_b[MSB_POS])) && (sum9[MSB_POS] != a[MSB_POS]);
        if (instr.op == OP_ADD_TO_M || instr.op == OP_ADC_TO_M ||
            instr.op == OP_SUB_TO_M || instr.op == OP_SBC_TO_M) begin
          wr_mem = 1'b1;
        end else begin
          wr_acc = 1'b1;
        end
      end
      OP_AND_M, OP_AND_TO_M, OP_AND_X, OP_OR_M, OP_OR_TO_M, OP_OR_X,
      OP_XOR_M, OP_XOR_TO_M, OP_XOR_X: begin
        if (instr.op == OP_AND_X || instr.op == OP_OR_X || instr.op == OP_XOR_X) begin
          m = instr.imm;
        end
        if (instr.op == OP_AND_M || instr.op == OP_AND_TO_M || instr.op == OP_AND_X) begin
          res = a & m;
        end else if (instr.op == OP_OR_M || instr.op == OP_OR_TO_M || instr.op == OP_OR_X) begin
          res = a | m;
        end else begin
          res = a ^ m;
        end
        flags_next.zero = (res == 8'h00);
        wr_mem = (instr.op == OP_AND_TO_M || instr.op == OP_OR_TO_M || instr.op == OP_XOR_TO_M);
        wr_acc = !wr_mem;
      end
      OP_CPL_M, OP_CPL_TO_A: begin
        res = ~m;
        flags_next.zero = (res == 8'h00);
        wr_mem = (instr.op == OP_CPL_M);
        wr_acc = (instr.op == OP_CPL_TO_A);
      end
      OP_RR_M, OP_RR_TO_A: begin
        res = {m[0], m[7:1]};
        wr_mem = (instr.op == OP_RR_M);
        wr_acc = !wr_mem;
      end
      OP_RL_M, OP_RL_TO_A: begin
        res = {m[6:0], m[7]};
        wr_mem = (instr.op == OP_RL_M);
        wr_acc = !wr_mem;
      end
      OP_RRC_M, OP_RRC_TO_A: begin
        res = {flags_reg.carry, m[7:1]};
        flags_next.carry = m[0];
        wr_mem = (instr.op == OP_RRC_M);
        wr_acc = !wr_mem;
      end
      OP_RLC_M, OP_RLC_TO_A: begin
        res = {m[6:0], flags_reg.carry};
        flags_next.carry = m[MSB_POS];
        wr_mem = (instr.op == OP_RLC_M);
        wr_acc = !wr_mem;
      end
      OP_BIT_CLR: begin
        res = m & ~bit_mask;
        wr_mem = 1'b1;
      end
      OP_BIT_SET: begin
        res = m | bit_mask;
        wr_mem = 1'b1;
      end
      OP_JUMP, OP_CALL, OP_RETURN, OP_TABLE_READ, OP_WRITE_PCL: begin
        extra_cycle = 1'b1;
        if (instr.op == OP_TABLE_READ) begin
          res = table_rdata;
          wr_mem = 1'b1;
        end
      end
      OP_SKIP_ZERO: begin
        skip_taken  = (m == 8'h00);
        extra_cycle = skip_taken;
      end
      OP_SKIP_BIT_Z, OP_SKIP_BIT_NZ: begin
        skip_taken  = ((m & bit_mask) == 8'h00) == (instr.op == OP_SKIP_BIT_Z);
        extra_cycle = skip_taken;
      end
      OP_NOP, OP_HALT: begin
        res = a;
      end
      default: begin
        res = a;
      end
    endcase
  end

  // program counter successor
  always_comb begin
    pc_next = pc_reg + 11'h001;
    unique case (instr.op)
      OP_JUMP, OP_CALL: pc_next = instr.target;
      OP_RETURN:        pc_next = stack_mem[sp_reg - SP_W'(1)];
      OP_WRITE_PCL:     pc_next = {pc_reg[10:8], accumulator_reg};
      default: begin
        if (skip_taken) begin
          pc_next = pc_reg + 11'h002;
        end
      end
    endcase
  end

  // sequencer: exec cycle, optional extra cycle, halt
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_EXEC: begin
        if (cycle_end && instr.op == OP_HALT) begin
          state_next = ST_HALT;
        end else if (cycle_end && extra_cycle) begin
          state_next = ST_EXTRA;
        end
      end
      ST_EXTRA: begin
        if (cycle_end) begin
          state_next = ST_EXEC;
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_next = ST_EXEC;
        end
      end
      default: state_next = ST_EXEC;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // architectural state commits at the end of the execute cycle only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      accumulator_reg <= ACC_RST;
      flags_reg       <= FLAGS_RST;
      pc_reg          <= PC_RST;
    end else if (state_reg == ST_EXEC && cycle_end) begin
      if (wr_acc) begin
        accumulator_reg <= res;
      end
      flags_reg <= flags_next;
      if (instr.op != OP_HALT) begin
        pc_reg <= pc_next; // halted core holds the next fetch address
      end else begin
        pc_reg <= pc_reg + 11'h001;
      end
    end
  end

  // return stack; call pushes successor, return pops. overflow wraps silently
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sp_reg <= '0;
    end else if (state_reg == ST_EXEC && cycle_end) begin
      if (instr.op == OP_CALL) begin
        sp_reg <= sp_reg + SP_W'(1);
      end else if (instr.op == OP_RETURN) begin
        sp_reg <= sp_reg - SP_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (state_reg == ST_EXEC && cycle_end && instr.op == OP_CALL) begin
      stack_mem[sp_reg] <= pc_reg + 11'h001;
    end
  end

  // memory write strobe is registered, so it lands one clock after the last clock of the execute cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_wdata <= 8'h00;
      mem_we    <= 1'b0;
    end else begin
      mem_wdata <= res;
      mem_we    <= (state_reg == ST_EXEC) && cycle_end && wr_mem;
    end
  end

  assign mem_addr    = instr.addr;
  assign table_addr  = {pc_reg[10:8], accumulator_reg};
  assign pc          = pc_reg;
  assign accumulator = accumulator_reg;
  assign flags       = flags_reg;
  assign halted      = (state_reg == ST_HALT);
  assign instr_done  = cycle_end && ((state_reg == ST_EXTRA) ||
                       (state_reg == ST_EXEC && !extra_cycle && instr.op != OP_HALT));

endmodule
`default_nettype wire

// >>> common/mabx_pkg.sv
package mabx_pkg;

  // instruction cycle geometry
  localparam int unsigned CLKS_PER_ICYCLE = 4;
  localparam int unsigned PHASE_W         = 2;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;

  // widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PC_W   = 11;
  localparam int unsigned OP_W   = 6;

  // reset values
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [10:0] PC_RST  = 11'h000;

  // bit positions used by flag logic
  localparam int unsigned MSB_POS    = 7;
  localparam int unsigned NIBBLE_POS = 4;

  // operations carried out by the core
  typedef enum logic [5:0] {
    OP_NOP        = 6'h00,
    OP_ADD_M      = 6'h01,
    OP_ADD_TO_M   = 6'h02,
    OP_ADD_X      = 6'h03,
    OP_ADC_M      = 6'h04,
    OP_ADC_TO_M   = 6'h05,
    OP_SUB_X      = 6'h06,
    OP_SUB_M      = 6'h07,
    OP_SUB_TO_M   = 6'h08,
    OP_SBC_M      = 6'h09,
    OP_SBC_TO_M   = 6'h0a,
    OP_AND_M      = 6'h0b,
    OP_OR_M       = 6'h0c,
    OP_XOR_M      = 6'h0d,
    OP_AND_TO_M   = 6'h0e,
    OP_OR_TO_M    = 6'h0f,
    OP_XOR_TO_M   = 6'h10,
    OP_AND_X      = 6'h11,
    OP_OR_X       = 6'h12,
    OP_XOR_X      = 6'h13,
    OP_CPL_M      = 6'h14,
    OP_CPL_TO_A   = 6'h15,
    OP_RR_M       = 6'h16,
    OP_RR_TO_A    = 6'h17,
    OP_RRC_M      = 6'h18,
    OP_RRC_TO_A   = 6'h19,
    OP_RL_M       = 6'h1a,
    OP_RL_TO_A    = 6'h1b,
    OP_RLC_M      = 6'h1c,
    OP_RLC_TO_A   = 6'h1d,
    OP_BIT_CLR    = 6'h1e,
    OP_BIT_SET    = 6'h1f,
    OP_JUMP       = 6'h20,
    OP_CALL       = 6'h21,
    OP_RETURN     = 6'h22,
    OP_SKIP_ZERO  = 6'h23,
    OP_SKIP_BIT_Z = 6'h24,
    OP_SKIP_BIT_NZ = 6'h25,
    OP_TABLE_READ = 6'h26,
    OP_HALT       = 6'h27,
    OP_WRITE_PCL  = 6'h28
  } mabx_op_type;

  // decoded instruction presented by the fetch stage
  typedef struct packed {
    mabx_op_type op;
    logic [7:0]  addr;
    logic [7:0]  imm;
    logic [2:0]  bit_sel;
    logic [10:0] target;
  } mabx_instr_type;

  // status flags
  typedef struct packed {
    logic zero;
    logic carry;
    logic aux_carry_flag;
    logic overflow_flag;
  } mabx_flags_type;

  localparam mabx_flags_type FLAGS_RST = '{default: 1'b0};

endpackage

// >>> bench/mabx_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mabx_core_assertions
  import mabx_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 8
) (
  input wire logic                     mclk,
  input wire logic                     nrst,
  input wire mabx_pkg::mabx_instr_type instr,
  input wire logic [7:0]               mem_rdata,
  input wire logic [7:0]               table_rdata,
  input wire logic                     wake,
  input wire logic [10:0]              pc,
  input wire logic [7:0]               mem_addr,
  input wire logic [7:0]               mem_wdata,
  input wire logic                     mem_we,
  input wire logic [10:0]              table_addr,
  input wire logic [7:0]               accumulator,
  input wire mabx_pkg::mabx_flags_type flags,
  input wire logic                     instr_done,
  input wire logic                     halted
);
  logic [7:0]     rd_q;
  logic [7:0]     acc_q;
  mabx_flags_type fl_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // operands as they stood on the commit edge
  always_ff @(posedge mclk) begin
    rd_q <= mem_rdata;
    acc_q <= accumulator;
    fl_q <= flags;
  end
  // last clock of one kind of instruction
  sequence s_do(mabx_op_type o); instr_done && instr.op == o; endsequence
  sequence s_asleep; halted [*4]; endsequence
  property p_logic_zero; s_do(OP_AND_M) |=> flags.zero == (accumulator == 8'h00); endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("zero flag after and");
  property p_rot_keep; s_do(OP_RR_TO_A) |=> flags == fl_q; endproperty
  a_rot_keep: assert property (p_rot_keep) else $error("rotate changed flags");
  property p_rrc; s_do(OP_RRC_TO_A) |=> {accumulator, flags.carry} == {fl_q.carry, rd_q}; endproperty
  a_rrc: assert property (p_rrc) else $error("rotate through carry");
  property p_add; s_do(OP_ADD_M) |=> {flags.carry, accumulator} == {1'b0, acc_q} + rd_q; endproperty
  a_add: assert property (p_add) else $error("add sum or carry");
  property p_sub_mem;
    s_do(OP_SUB_TO_M) |=> mem_we && mem_wdata == 8'(acc_q - rd_q) && accumulator == acc_q;
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory");
  property p_jump; s_do(OP_JUMP) |-> pc == instr.target; endproperty
  a_jump: assert property (p_jump) else $error("jump target");
  // halt never raises instr_done, so entry into the halted state is the trigger
  property p_halt;
    $rose(halted) |-> ($past(instr.op) == OP_HALT) ##0 s_asleep;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_gap; instr_done |=> !instr_done [*3]; endproperty
  a_gap: assert property (p_gap) else $error("instruction shorter than four clocks");
endmodule
bind mabx_core mabx_core_assertions #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
  .mclk(mclk), .nrst(nrst), .instr(instr), .mem_rdata(mem_rdata), .table_rdata(table_rdata),
  .wake(wake), .pc(pc), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
  .table_addr(table_addr), .accumulator(accumulator), .flags(flags),
  .instr_done(instr_done), .halted(halted));
`default_nettype wire

// >>> bench/mabx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mabx_mem_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  input  wire logic [10:0] table_addr,
  output logic [7:0]       mem_rdata,
  output logic [7:0]       table_rdata
);
  logic [7:0] mem [256];
  logic [7:0] wa;
  // each byte starts as its own address, so the bench knows every value
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  // strobe trails the commit; the address may already have moved on
  always @(posedge mclk) begin
    wa <= mem_addr;
    if (mem_we) mem[wa] <= mem_wdata;
  end
  assign mem_rdata = mem[mem_addr];
  // inverted low address, so a wrong byte shows up; the page bits do not reach the data
  assign table_rdata = ~table_addr[7:0];
endmodule
`default_nettype wire

// >>> bench/test_mabx_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_mabx_core;
  import mabx_pkg::*;
  logic           mclk, nrst, wake, mem_we, instr_done, halted;
  logic [7:0]     mem_rdata, table_rdata, mem_addr, mem_wdata, accumulator;
  logic [10:0]    pc, table_addr, p;
  mabx_instr_type instr;
  mabx_flags_type flags;
  int             bad_count, cmp_count, n;

  mabx_core #(.STACK_DEPTH(8)) uut (
    .mclk(mclk), .nrst(nrst), .instr(instr), .mem_rdata(mem_rdata), .table_rdata(table_rdata),
    .wake(wake), .pc(pc), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .table_addr(table_addr), .accumulator(accumulator), .flags(flags),
    .instr_done(instr_done), .halted(halted));
  mabx_mem_model mdl (
    .mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .table_addr(table_addr), .mem_rdata(mem_rdata), .table_rdata(table_rdata));

  // 10 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // present at a falling edge, hold until the last clock, n counts edges
  task automatic exec(input mabx_op_type op, input logic [7:0] a, input logic [2:0] b,
                      input logic [10:0] t);
    p = pc;
    instr = '{op, a, a, b, t};
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (instr_done !== 1'b1 && n < 20);
    @(negedge mclk);
  endtask

  task automatic step(input mabx_op_type op, input logic [7:0] a, input logic [7:0] ea,
                      input logic [3:0] ef, input logic [3:0] m);
    exec(op, a, 3'h0, 11'h000);
    chk(accumulator === ea && (flags & m) === (ef & m), "result or flags");
    chk(n == 3 && pc === p + 11'h001, "one cycle");
  endtask

  // a nop lets the trailing write land before the byte is read back
  task automatic mchk(input logic [7:0] a, input logic [7:0] v);
    exec(OP_NOP, 8'h00, 3'h0, 11'h000);
    chk(mdl.mem[a] === v, "memory byte");
  endtask

  task automatic br(input mabx_op_type op, input logic [7:0] a, input logic [2:0] b,
                    input int en, input logic [10:0] ep);
    exec(op, a, b, ep);
    chk(n == en && pc === ep, "branch");
  endtask

  task automatic t_alu;
    step(OP_ADD_X, 8'h7f, 8'h7f, 4'b0000, 4'hf);
    step(OP_ADD_X, 8'h01, 8'h80, 4'b0011, 4'hf);
    step(OP_ADD_M, 8'h80, 8'h00, 4'b1101, 4'hf);
    step(OP_ADC_M, 8'h0f, 8'h10, 4'b0010, 4'hf);
    step(OP_SUB_X, 8'h21, 8'hef, 4'b0000, 4'hd);
    step(OP_SBC_M, 8'h0e, 8'he0, 4'b0100, 4'hd);
    step(OP_SUB_TO_M, 8'h7f, 8'he0, 4'b0101, 4'hd);
    mchk(8'h7f, 8'h61);
    step(OP_AND_M, 8'h1f, 8'h00, 4'b1101, 4'hd);
    step(OP_OR_M, 8'h5a, 8'h5a, 4'b0101, 4'hd);
    step(OP_XOR_M, 8'h5a, 8'h00, 4'b1101, 4'hd);
    step(OP_CPL_TO_A, 8'h0f, 8'hf0, 4'b0101, 4'hd);
    mchk(8'h0f, 8'h0f);
    step(OP_RRC_TO_A, 8'h03, 8'h81, 4'b0101, 4'hd);
    step(OP_RLC_TO_A, 8'h40, 8'h81, 4'b0001, 4'hd);
    step(OP_RR_TO_A, 8'h01, 8'h80, 4'b0001, 4'hd);
    step(OP_RL_TO_A, 8'h81, 8'h03, 4'b0001, 4'hd);
  endtask

  task automatic t_branch;
    br(OP_SKIP_ZERO, 8'h00, 3'h0, 7, pc + 11'h002);
    br(OP_SKIP_ZERO, 8'h01, 3'h0, 3, pc + 11'h001);
    br(OP_SKIP_BIT_Z, 8'h20, 3'h0, 7, pc + 11'h002);
    br(OP_SKIP_BIT_NZ, 8'h20, 3'h0, 3, pc + 11'h001);
    br(OP_JUMP, 8'h00, 3'h0, 7, 11'h123);
    br(OP_CALL, 8'h00, 3'h0, 7, 11'h200);
    br(OP_JUMP, 8'h00, 3'h0, 7, 11'h300);
    br(OP_RETURN, 8'h00, 3'h0, 7, 11'h124);
    br(OP_TABLE_READ, 8'h30, 3'h0, 7, 11'h125);
    chk(table_addr === 11'h103, "table address");
    mchk(8'h30, 8'hfc);
    br(OP_WRITE_PCL, 8'h00, 3'h0, 7, 11'h103);
  endtask

  task automatic t_bits;
    for (int b = 0; b < 8; b++) begin
      exec(OP_BIT_SET, 8'h00, b[2:0], 11'h000);
      mchk(8'h00, 8'((2 << b) - 1));
    end
    exec(OP_BIT_CLR, 8'h00, 3'h4, 11'h000);
    mchk(8'h00, 8'hef);
  endtask

  task automatic t_halt;
    exec(OP_HALT, 8'h00, 3'h0, 11'h000);
    instr.op = OP_NOP;
    repeat (10) begin
      @(negedge mclk);
      chk(halted === 1'b1 && instr_done === 1'b0 && pc === p + 11'h001, "halt");
    end
    wake = 1'b1;
    n = 0;
    while (halted !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    wake = 1'b0;
    exec(OP_ADD_X, 8'h01, 3'h0, 11'h000);
    chk(n < 20 && accumulator === 8'h04, "resume");
  endtask

  // reset for six cycles, then the scenarios back to back
  initial begin
    nrst = 1'b0;
    wake = 1'b0;
    instr = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(negedge mclk);
    chk(pc === 11'h000 && accumulator === 8'h00 && flags === FLAGS_RST, "reset");
    nrst = 1'b1;
    t_alu();
    t_branch();
    t_bits();
    t_halt();
    end_sim();
  end

  // whole run is a few hundred clocks, under a hundred instruction cycles; this cuts off a hang
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
